// File: pkg/pls_pkg.sv
// Purpose: Constants and carriers for the Phy_link_state and interrupt enable bank
// Assumes: 16-bit registers reached over a plain strobe port, word index addressing
// Notes:   Offsets are register indices
package pls_pkg;

  localparam int          PLS_ADDR_W       = 5;
  localparam int          PLS_DATA_W       = 16;
  localparam logic [4:0]  PLS_OFF_STATUS   = 5'h11;
  localparam logic [4:0]  PLS_OFF_IRQ_EN   = 5'h12;
  localparam logic [4:0]  PLS_OFF_IRQ_STAT = 5'h13;
  localparam logic [15:0] PLS_RST_STATUS   = 16'h0000;
  localparam logic [15:0] PLS_RST_IRQ_EN   = 16'h0000;
  localparam logic [15:0] PLS_RST_IRQ_STAT = 16'h0000;
  localparam logic [15:0] PLS_IRQ_EN_WMASK = 16'hFF80;

  // Status field positions
  localparam int PLS_B_SPEED_HI = 15;
  localparam int PLS_B_SPEED_LO = 14;
  localparam int PLS_B_DUPLEX   = 13;
  localparam int PLS_B_PAGE     = 12;
  localparam int PLS_B_RESOLVED = 11;
  localparam int PLS_B_LINK     = 10;
  localparam int PLS_B_XCD      = 9;
  localparam int PLS_B_XAB      = 8;
  localparam int PLS_B_DOWNSH   = 7;
  localparam int PLS_B_SLEEP    = 6;
  localparam int PLS_B_POL_HI   = 5;
  localparam int PLS_B_POL_LO   = 2;
  localparam int PLS_B_POL10    = 1;
  localparam int PLS_B_JABBER   = 0;

  // Event positions, shared by enable and event status registers
  localparam int PLS_EV_LO  = 7;
  localparam int PLS_EV_NUM = 9;

  localparam logic [1:0] PLS_SPEED_10   = 2'h0;
  localparam logic [1:0] PLS_SPEED_100  = 2'h1;
  localparam logic [1:0] PLS_SPEED_1000 = 2'h2;

  typedef struct packed {
    logic [1:0] speed;
    logic       full_duplex;
    logic       page_rx;
    logic       neg_enabled;
    logic       neg_complete;
    logic       link_up;
    logic       crossover_pairs_cd;
    logic       crossover_pairs_ab;
    logic       downshift_active;
    logic       sleeping;
    logic [3:0] pair_polarity_flags;
    logic       pol10_reversed;
    logic       jabber_detected;
  } pls_phy_s;

  typedef struct packed {
    logic neg_error;
    logic rate_change;
    logic duplex_change;
    logic page_rx;
    logic neg_done;
    logic link_change;
    logic energy_eff_error;
    logic bogus_carrier;
    logic converter_fifo_fault;
  } pls_evt_s;

endpackage

// File: hdl/pls_regs.sv
// Purpose: PHY link state register and event interrupt enable register bank
// Assumes: Live PHY state and one-cycle event pulses synchronous to clk_sys
// Notes:   Read data valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Status bits 15-14 give resolved speed: 0 is 10M, 1 is 100M, 2 is 1000M, 3 reserved.
// - Status bit 13 is read-only and shows 0 for half and 1 for full duplex.
// - Status bit 12 latches on a received page and clears when the register is read.
// - Status bit 11 is 0 while negotiation runs unfinished, else 1.
// - Status bit 10 shows link up as 1 and link down as 0.
// - Status bits 9 and 8 show crossover of pairs C/D and A/B, 1 meaning crossed.
// - Status bit 7 is 1 only while negotiation runs with gigabit abilities masked.
// - Status bit 6 is 1 in sleep and 0 when active.
// - Status bits 5-2 show reversed polarity of channels D, C, B, A.
// - Status bit 1 is 1 for normal and 0 for reversed 10M receive polarity.
// - Status bit 0 is 1 while jabber is detected.
// - The status register resets to zero and only the page flag changes on read.
// - The enable register resets to zero so no event interrupts at first.
// - An event raises the interrupt only when its enable bit is set.
// - Enable bits 15 to 7 gate the nine events in their fixed order.
module pls_regs
  import pls_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [PLS_ADDR_W-1:0] reg_addr,
  input  wire logic [PLS_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [PLS_DATA_W-1:0] reg_rdata,
  input  wire pls_phy_s              phy_in,
  input  wire pls_evt_s              evt_in,
  output logic                       irq
);

  logic [PLS_DATA_W-1:0] status_q;
  logic [PLS_DATA_W-1:0] status_d;
  logic                  page_q;
  logic [PLS_DATA_W-1:0] irq_en_q;
  logic [PLS_DATA_W-1:0] irq_stat_q;
  logic [PLS_DATA_W-1:0] evt_vec;
  logic                  rd_status;
  logic                  rd_irq_stat;

  assign rd_status   = reg_rd && (reg_addr == PLS_OFF_STATUS);
  assign rd_irq_stat = reg_rd && (reg_addr == PLS_OFF_IRQ_STAT);

  // Page flag: set wins over read clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      page_q <= 1'b0;
    end else if (phy_in.page_rx) begin
      page_q <= 1'b1;
    end else if (rd_status) begin
      page_q <= 1'b0;
    end
  end

  // Live status image
  always_comb begin
    status_d = PLS_RST_STATUS;
    status_d[PLS_B_SPEED_HI:PLS_B_SPEED_LO] = phy_in.speed;
    status_d[PLS_B_DUPLEX]   = phy_in.full_duplex;
    status_d[PLS_B_PAGE]     = page_q;
    status_d[PLS_B_RESOLVED] = phy_in.neg_complete || !phy_in.neg_enabled;
    status_d[PLS_B_LINK]     = phy_in.link_up;
    status_d[PLS_B_XCD]      = phy_in.crossover_pairs_cd;
    status_d[PLS_B_XAB]      = phy_in.crossover_pairs_ab;
    status_d[PLS_B_DOWNSH]   = phy_in.downshift_active && phy_in.neg_enabled
                               && !phy_in.neg_complete;
    status_d[PLS_B_SLEEP]    = phy_in.sleeping;
    status_d[PLS_B_POL_HI:PLS_B_POL_LO] = phy_in.pair_polarity_flags;
    status_d[PLS_B_POL10]    = !phy_in.pol10_reversed;
    status_d[PLS_B_JABBER]   = phy_in.jabber_detected;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= PLS_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Enable register, only event bits writable
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= PLS_RST_IRQ_EN;
    end else if (reg_wr && (reg_addr == PLS_OFF_IRQ_EN)) begin
      irq_en_q <= reg_wdata & PLS_IRQ_EN_WMASK;
    end
  end

  assign evt_vec = {evt_in, {PLS_EV_LO{1'b0}}};

  // Sticky event status, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < PLS_DATA_W; gi++) begin : g_evt
      if (gi >= PLS_EV_LO) begin : g_live
        always_ff @(posedge clk_sys or posedge sys_rst) begin
          if (sys_rst) begin
            irq_stat_q[gi] <= PLS_RST_IRQ_STAT[gi];
          end else if (evt_vec[gi]) begin
            irq_stat_q[gi] <= 1'b1;
          end else if (reg_wr && (reg_addr == PLS_OFF_IRQ_STAT) && reg_wdata[gi]) begin
            irq_stat_q[gi] <= 1'b0;
          end
        end
      end else begin : g_rsvd
        always_ff @(posedge clk_sys or posedge sys_rst) begin
          if (sys_rst) begin
            irq_stat_q[gi] <= PLS_RST_IRQ_STAT[gi];
          end else begin
            irq_stat_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign irq = |(irq_stat_q & irq_en_q);

  // Read data, one cycle after strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (rd_status) begin
      reg_rdata             <= status_q;
      reg_rdata[PLS_B_PAGE] <= page_q;
    end else if (reg_rd && (reg_addr == PLS_OFF_IRQ_EN)) begin
      reg_rdata <= irq_en_q;
    end else if (rd_irq_stat) begin
      reg_rdata <= irq_stat_q;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// File: verification/pls_host.sv
// Purpose: Management host model on the register port
// Assumes: One strobe per cycle, driven after the rising edge
// Notes: q holds the expected data of each read
`timescale 1ns/1ps
`default_nettype none
module pls_host (
  input  wire logic   clk_sys,
  output logic [4:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  logic [15:0] q[$];
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  task op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w ? d : ~reg_wdata;
    reg_wr <= w;
    reg_rd <= r;
    if (r) q.push_back(d);
  endtask
endmodule
`default_nettype wire

// File: verification/pls_assertions.sv
// Purpose: Port checks of pls_regs
// Assumes: phy_in steady around status reads
// Notes: Bound to every pls_regs
`timescale 1ns/1ps
`default_nettype none
module pls_chk import pls_pkg::*; (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire pls_phy_s    phy_in,
  input wire pls_evt_s    evt_in,
  input wire logic        irq
);
  pls_phy_s p1, p2;
  always_ff @(posedge clk_sys) p1 <= phy_in;
  always_ff @(posedge clk_sys) p2 <= p1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s; reg_rd && reg_addr == PLS_OFF_STATUS; endsequence
  sequence s2; s ##1 s; endsequence
  speed_field_a: assert property (s |=> reg_rdata[15:14] == p2.speed)
    else $error("bad speed");
  page_flag_a: assert property (s2 |=> reg_rdata[12] == p2.page_rx)
    else $error("page flag not cleared by read");
  dup_link_a: assert property (s |=> {reg_rdata[13], reg_rdata[10]} ==
    {p2.full_duplex, p2.link_up}) else $error("bad duplex");
  neg_state_a: assert property (s |=> reg_rdata[11] ==
    (!p2.neg_enabled || p2.neg_complete)) else $error("bad resolved");
  low_bits_a: assert property (s |=> reg_rdata[5:0] ==
    {p2.pair_polarity_flags, !p2.pol10_reversed, p2.jabber_detected}) else $error("bad low");
  idle_zero_a: assert property (!$past(reg_rd) |-> !reg_rdata)
    else $error("rdata not idle");
  unmapped_a: assert property (reg_rd && reg_addr > 5'h13 |=> !reg_rdata)
    else $error("unmapped data");
  en_low_a: assert property (reg_rd && reg_addr == PLS_OFF_IRQ_EN |=> !reg_rdata[6:0])
    else $error("enable low bits");
  irq_cause_a: assert property ($rose(irq) |-> $past(evt_in) != 9'h000 || $past(reg_wr))
    else $error("irq without cause");
endmodule
bind pls_regs pls_chk pls_chk_i (.*);
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Self-checking bench of pls_regs
// Assumes: Host model h drives the register port
// Notes: Reads scored against h.q
`timescale 1ns/1ps
`default_nettype none
module tb_top import pls_pkg::*; ;
  logic clk_sys = 0, sys_rst = 1, reg_wr, reg_rd, irq, rd_d = 0;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lf = 16'h0061;
  pls_phy_s phy = '0;
  pls_evt_s evt = '0;
  int mismatches = 0, check_count = 0;
  always #2 clk_sys = ~clk_sys;
  pls_host h (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
  pls_regs pls_regs_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .phy_in(phy), .evt_in(evt), .irq);
  task chk(input logic [15:0] g, e, input string n);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task results;
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] st(pls_phy_s p, logic pg);
    return {p.speed, p.full_duplex, pg, !p.neg_enabled || p.neg_complete, p.link_up,
      p.crossover_pairs_cd, p.crossover_pairs_ab, p.downshift_active && p.neg_enabled
      && !p.neg_complete, p.sleeping, p.pair_polarity_flags, !p.pol10_reversed,
      p.jabber_detected};
  endfunction
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) if (rd_d) chk(reg_rdata, h.q.pop_front(), "rdata");
  initial begin
    #100000;
    mismatches++;
    results;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 0;
    h.op(0, 1, PLS_OFF_STATUS, st(phy, 1'b0));
    h.op(0, 1, PLS_OFF_IRQ_EN, 16'h0000);
    h.op(0, 1, 5'h1F, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      lf = nx(lf);
      h.op(1, 0, PLS_OFF_IRQ_EN, lf);
      h.op(0, 1, PLS_OFF_IRQ_EN, lf & 16'hFF80);
      phy <= {k[1:0], lf[0], 1'b0, lf[15:3]};
      h.op(1, 0, PLS_OFF_STATUS, 16'hFFFF);
      h.op(0, 1, PLS_OFF_STATUS, st(phy, 1'b0));
    end
    phy.page_rx <= 1;
    h.op(0, 0, 0, 0);
    phy.page_rx <= 0;
    h.op(0, 1, PLS_OFF_STATUS, st(phy, 1'b1));
    h.op(0, 1, PLS_OFF_STATUS, st(phy, 1'b0));
    for (int i = 0; i < 9; i++) begin
      h.op(1, 0, PLS_OFF_IRQ_EN, ~(16'h8000 >> i) & 16'hFF80);
      h.op(0, 0, 0, 0);
      evt <= 9'h100 >> i;
      h.op(0, 0, 0, 0);
      evt <= '0;
      @(negedge clk_sys) chk({15'h0, irq}, 16'h0000, "irq");
      h.op(1, 0, PLS_OFF_IRQ_EN, 16'h8000 >> i);
      h.op(0, 1, PLS_OFF_IRQ_STAT, 16'h8000 >> i);
      @(negedge clk_sys) chk({15'h0, irq}, 16'h0001, "irq");
      h.op(1, 0, PLS_OFF_IRQ_STAT, 16'hFFFF);
      h.op(0, 0, 0, 0);
      @(negedge clk_sys) chk({15'h0, irq}, 16'h0000, "irq");
    end
    for (int w = 0; w < 9 && h.q.size() > 0; w++) @(posedge clk_sys);
    if (h.q.size() > 0) mismatches++;
    results;
  end
endmodule
`default_nettype wire
